// >>> design/cod_pkg.sv
// Shared constants and types for the operand field decoder
package cod_pkg;

  // Opcode of the register-to-register add form
  localparam logic [7:0] ADD_RR_OPC = 8'h04;
  // Upper nibble that marks an escaped working register
  localparam logic [3:0] ESC_NIBBLE = 4'hE;

  // Bit operand byte layout
  localparam int BIT_POL_POS = 0;
  localparam int BIT_NUM_LSB = 1;
  localparam int BIT_NUM_W = 3;

  // Operand byte counts
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // Reset values
  localparam logic [11:0] REG_ADDR_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [3:0] {
    K_ADD_RR,  // src reg byte, dst reg byte
    K_LONG,    // 12-bit long register address, two bytes
    K_DIRECT,  // 16-bit direct address, high byte first
    K_LITERAL, // dst reg byte, literal byte
    K_BIT,     // bit and polarity byte, dst reg byte
    K_JUMP,    // signed jump displacement byte
    K_INDEX,   // base reg byte, signed index byte
    K_PTR,     // pointer register byte
    K_PTR_PAIR,// pointer register pair byte, even
    K_WPAIR,   // working pair nibble, even
    K_VECTOR   // vector byte
  } cod_kind_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_OPND,
    S_ADDW
  } cod_state_t;

endpackage : cod_pkg

// >>> design/cod_alu_if.sv
// Carrier between the decoder and its add unit
`timescale 1ns/1ps
`default_nettype none
interface cod_alu_if;
  logic go;
  logic [7:0] a;
  logic [7:0] b;
  logic [11:0] addr;
  logic done;
  logic [7:0] sum;
  logic [11:0] wb_addr;

  modport dec (output go, output a, output b, output addr,
               input done, input sum, input wb_addr);
  modport unit (input go, input a, input b, input addr,
                output done, output sum, output wb_addr);
endinterface : cod_alu_if
`default_nettype wire

// >>> design/cod_add_unit.sv
// Add unit: sums source and destination values and returns the write-back
`timescale 1ns/1ps
`default_nettype none
module cod_add_unit (
  input wire logic ref_clk,
  input wire logic resetn,
  cod_alu_if.unit alu
);

  typedef struct packed {
    logic done;
    logic [7:0] sum;
    logic [11:0] wb_addr;
  } cod_add_st_t;

  cod_add_st_t q_r;
  cod_add_st_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = alu.go;
    if (alu.go) begin
      // Carry is dropped; flags live elsewhere
      q_nxt.sum = 8'(alu.a + alu.b);
      q_nxt.wb_addr = alu.addr;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '{done: 1'b0, sum: cod_pkg::BYTE_RST, wb_addr: cod_pkg::REG_ADDR_RST};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign alu.done = q_r.done;
  assign alu.sum = q_r.sum;
  assign alu.wb_addr = q_r.wb_addr;

  chk_add_sum_dest: assert property (@(posedge ref_clk) disable iff (!resetn)
    alu.go |=> alu.done && alu.sum == 8'($past(alu.a) + $past(alu.b))
      && alu.wb_addr == $past(alu.addr))
    else $error("add result or destination wrong");

endmodule : cod_add_unit
`default_nettype wire

// >>> design/cod_top.sv
// Operand field decoder: turns instruction object-code bytes into operand values
// Notes on behaviour
// - Add opcode 04 lists the source operand byte before the destination byte; the literal form lists the destination byte first.
// - A register byte names any register 00 to FF except E0 to EF, which are escape byte E-n naming working register n.
// - A bit-number field is three bits selecting bit 0 to 7.
// - A direct address is a full 16-bit value from two bytes.
// - A long register address is a 12-bit value covering the whole register file.
// - A literal operand is an 8-bit value carried in the instruction.
// - A pointer pair operand is an even register address naming the pair holding the address.
// - A jump displacement is signed 8-bit, added to the address of the next instruction.
// - An indexed operand adds a signed 8-bit index to the contents of its base.
// - The polarity operand is one bit choosing a cleared or set condition.
// - A vector operand is an 8-bit vector address.
// - Add writes the sum of source and destination back to the destination.
// - A pointer operand is an 8-bit register address whose contents give the real address.
`timescale 1ns/1ps
`default_nettype none
module cod_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire logic fetch_first,
  input wire logic [7:0] fetch_byte,
  input wire cod_pkg::cod_kind_t fetch_kind,
  input wire logic [15:0] fetch_pc,
  input wire logic [7:0] working_bank_pointer,
  input wire logic [15:0] index_base,
  output logic dec_valid,
  output cod_pkg::cod_kind_t dec_kind,
  output logic [11:0] src_addr,
  output logic [11:0] dst_addr,
  output logic [15:0] direct_address_operand,
  output logic [7:0] literal_byte_operand,
  output logic [2:0] bit_num,
  output logic bit_polarity,
  output logic [7:0] vector_addr,
  output logic [15:0] eff_addr,
  output logic pair_err,
  output logic add_req,
  input wire logic val_valid,
  input wire logic [7:0] src_val,
  input wire logic [7:0] dst_val,
  output logic wb_valid,
  output logic [11:0] wb_addr,
  output logic [7:0] wb_data
);

  typedef struct packed {
    cod_pkg::cod_state_t st;
    cod_pkg::cod_kind_t kind;
    logic [7:0] opc;
    logic [7:0] rp;
    logic [15:0] pc;
    logic [1:0] cnt;
    logic [7:0] b0;
    logic [7:0] b1;
    logic dec_valid;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [15:0] direct;
    logic [7:0] literal;
    logic [2:0] bit_num;
    logic polarity;
    logic [7:0] vector;
    logic [15:0] eff;
    logic pair_err;
  } cod_dec_t;

  localparam cod_dec_t DEC_RST = '{
    st: cod_pkg::S_IDLE, kind: cod_pkg::K_ADD_RR, opc: cod_pkg::BYTE_RST,
    rp: cod_pkg::BYTE_RST, pc: cod_pkg::WORD_RST, cnt: 2'h0,
    b0: cod_pkg::BYTE_RST, b1: cod_pkg::BYTE_RST, dec_valid: 1'b0,
    src_addr: cod_pkg::REG_ADDR_RST, dst_addr: cod_pkg::REG_ADDR_RST,
    direct: cod_pkg::WORD_RST, literal: cod_pkg::BYTE_RST, bit_num: 3'h0,
    polarity: 1'b0, vector: cod_pkg::BYTE_RST, eff: cod_pkg::WORD_RST,
    pair_err: 1'b0};

  cod_dec_t q_r;
  cod_dec_t q_nxt;

  cod_alu_if alu ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [1:0] op_len(input cod_pkg::cod_kind_t k);
    case (k)
      cod_pkg::K_JUMP, cod_pkg::K_PTR, cod_pkg::K_PTR_PAIR,
      cod_pkg::K_WPAIR, cod_pkg::K_VECTOR: op_len = cod_pkg::LEN_ONE;
      default: op_len = cod_pkg::LEN_TWO;
    endcase
  endfunction : op_len

  // Working register n lives at {pointer low, pointer high, n}
  function automatic logic [11:0] work_addr(input logic [7:0] rp, input logic [3:0] n);
    work_addr = {rp[3:0], rp[7:4], n};
  endfunction : work_addr

  function automatic logic [11:0] reg_addr(input logic [7:0] b, input logic [7:0] rp);
    if (b[7:4] == cod_pkg::ESC_NIBBLE) begin
      reg_addr = work_addr(rp, b[3:0]);
    end else begin
      reg_addr = {4'h0, b};
    end
  endfunction : reg_addr

  function automatic logic [15:0] sext(input logic [7:0] d);
    sext = {{8{d[7]}}, d};
  endfunction : sext

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic accept;
  assign fetch_ready = (q_r.st != cod_pkg::S_ADDW);
  assign accept = fetch_valid && fetch_ready;

  always_comb begin
    logic [7:0] b0n;
    logic [7:0] b1n;
    logic [15:0] next_pc;
    b0n = q_r.b0;
    b1n = q_r.b1;
    next_pc = 16'(q_r.pc + 16'(op_len(q_r.kind)) + 16'h0001);
    q_nxt = q_r;
    q_nxt.dec_valid = 1'b0;
    case (q_r.st)
      cod_pkg::S_IDLE: begin
        // Stray operand bytes outside an instruction are dropped
        if (accept && fetch_first) begin
          q_nxt.opc = fetch_byte;
          q_nxt.kind = fetch_kind;
          q_nxt.rp = working_bank_pointer;
          q_nxt.pc = fetch_pc;
          q_nxt.cnt = 2'h0;
          q_nxt.st = cod_pkg::S_OPND;
        end
      end
      cod_pkg::S_OPND: begin
        if (accept) begin
          if (q_r.cnt == 2'h0) begin
            b0n = fetch_byte;
          end else begin
            b1n = fetch_byte;
          end
          q_nxt.b0 = b0n;
          q_nxt.b1 = b1n;
          q_nxt.cnt = 2'(q_r.cnt + 2'h1);
          if (2'(q_r.cnt + 2'h1) == op_len(q_r.kind)) begin
            q_nxt.dec_valid = 1'b1;
            q_nxt.pair_err = 1'b0;
            q_nxt.st = cod_pkg::S_IDLE;
            case (q_r.kind)
              cod_pkg::K_ADD_RR: begin
                q_nxt.src_addr = reg_addr(b0n, q_r.rp);
                q_nxt.dst_addr = reg_addr(b1n, q_r.rp);
                if (q_r.opc == cod_pkg::ADD_RR_OPC) begin
                  q_nxt.st = cod_pkg::S_ADDW;
                end
              end
              cod_pkg::K_LONG: q_nxt.dst_addr = {b0n[3:0], b1n};
              cod_pkg::K_DIRECT: q_nxt.direct = {b0n, b1n};
              cod_pkg::K_LITERAL: begin
                q_nxt.dst_addr = reg_addr(b0n, q_r.rp);
                q_nxt.literal = b1n;
              end
              cod_pkg::K_BIT: begin
                q_nxt.bit_num = b0n[cod_pkg::BIT_NUM_LSB +: cod_pkg::BIT_NUM_W];
                q_nxt.polarity = b0n[cod_pkg::BIT_POL_POS];
                q_nxt.dst_addr = reg_addr(b1n, q_r.rp);
              end
              cod_pkg::K_JUMP: q_nxt.eff = 16'(next_pc + sext(b0n));
              cod_pkg::K_INDEX: begin
                q_nxt.src_addr = reg_addr(b0n, q_r.rp);
                q_nxt.eff = 16'(index_base + sext(b1n));
              end
              cod_pkg::K_PTR: q_nxt.src_addr = reg_addr(b0n, q_r.rp);
              cod_pkg::K_PTR_PAIR: begin
                q_nxt.src_addr = reg_addr(b0n, q_r.rp);
                q_nxt.pair_err = b0n[0];
              end
              cod_pkg::K_WPAIR: begin
                q_nxt.src_addr = work_addr(q_r.rp, b0n[3:0]);
                q_nxt.pair_err = b0n[0];
              end
              cod_pkg::K_VECTOR: q_nxt.vector = b0n;
              default: q_nxt.pair_err = 1'b0;
            endcase
          end
        end
      end
      cod_pkg::S_ADDW: begin
        // Fetch stalls until the register file returns both values
        if (val_valid) begin
          q_nxt.st = cod_pkg::S_IDLE;
        end
      end
      default: q_nxt = DEC_RST;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= DEC_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Add path

  assign add_req = (q_r.st == cod_pkg::S_ADDW);
  assign alu.go = add_req && val_valid;
  assign alu.a = src_val;
  assign alu.b = dst_val;
  assign alu.addr = q_r.dst_addr;

  cod_add_unit u_add (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .alu(alu)
  );

  assign wb_valid = alu.done;
  assign wb_addr = alu.wb_addr;
  assign wb_data = alu.sum;

  assign dec_valid = q_r.dec_valid;
  assign dec_kind = q_r.kind;
  assign src_addr = q_r.src_addr;
  assign dst_addr = q_r.dst_addr;
  assign direct_address_operand = q_r.direct;
  assign literal_byte_operand = q_r.literal;
  assign bit_num = q_r.bit_num;
  assign bit_polarity = q_r.polarity;
  assign vector_addr = q_r.vector;
  assign eff_addr = q_r.eff;
  assign pair_err = q_r.pair_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_src_first_plain: assert property (
    dec_valid && dec_kind == cod_pkg::K_ADD_RR && q_r.b0[7:4] != 4'hE
      |-> src_addr == {4'h0, q_r.b0})
    else $error("source register not taken from first operand byte");
  chk_escape_work_reg: assert property (
    dec_valid && dec_kind == cod_pkg::K_ADD_RR && q_r.b1[7:4] == 4'hE
      |-> dst_addr == {q_r.rp[3:0], q_r.rp[7:4], q_r.b1[3:0]})
    else $error("escaped working register address wrong");
  chk_bit_fields: assert property (
    dec_valid && dec_kind == cod_pkg::K_BIT
      |-> bit_num == q_r.b0[3:1] && bit_polarity == q_r.b0[0])
    else $error("bit number or polarity wrong");
  chk_direct_word: assert property (
    dec_valid && dec_kind == cod_pkg::K_DIRECT |-> direct_address_operand == {q_r.b0, q_r.b1})
    else $error("direct address wrong");
  chk_long_reg: assert property (
    dec_valid && dec_kind == cod_pkg::K_LONG |-> dst_addr == {q_r.b0[3:0], q_r.b1})
    else $error("long register address wrong");
  chk_literal_byte: assert property (
    dec_valid && dec_kind == cod_pkg::K_LITERAL |-> literal_byte_operand == q_r.b1)
    else $error("literal wrong");
  chk_pair_even: assert property (
    dec_valid && (dec_kind == cod_pkg::K_WPAIR || dec_kind == cod_pkg::K_PTR_PAIR)
      |-> pair_err == q_r.b0[0])
    else $error("odd pair not flagged");
  chk_jump_target: assert property (
    dec_valid && dec_kind == cod_pkg::K_JUMP
      |-> eff_addr == 16'(q_r.pc + 16'h0002 + {{8{q_r.b0[7]}}, q_r.b0}))
    else $error("jump target wrong");
  chk_index_sum: assert property (
    dec_valid && dec_kind == cod_pkg::K_INDEX
      |-> eff_addr == 16'($past(index_base) + {{8{q_r.b1[7]}}, q_r.b1}))
    else $error("indexed address wrong");
  chk_vector_byte: assert property (
    dec_valid && dec_kind == cod_pkg::K_VECTOR |-> vector_addr == q_r.b0)
    else $error("vector wrong");
  chk_add_wait: assert property (
    add_req && val_valid |=> !add_req ##0 wb_valid ##0 wb_addr == $past(dst_addr))
    else $error("add write-back missing");

  cov_add_done: cover property (add_req ##1 wb_valid);
  cov_escaped: cover property (dec_valid && q_r.b0[7:4] == 4'hE);
  cov_jump: cover property (dec_valid && dec_kind == cod_pkg::K_JUMP);
  cov_odd_pair: cover property (dec_valid && pair_err);

endmodule : cod_top
`default_nettype wire

// >>> testbench/cod_prog_mem.sv
// Program memory model that streams instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module cod_prog_mem (
  input wire logic ref_clk,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic fetch_first,
  output logic [7:0] fetch_byte,
  output cod_pkg::cod_kind_t fetch_kind,
  output logic [15:0] fetch_pc
);
  logic [7:0] mem [0:255];

  initial begin
    fetch_valid = 1'b0;
    fetch_first = 1'b0;
    fetch_byte = 8'h00;
    fetch_kind = cod_pkg::K_ADD_RR;
    fetch_pc = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1,
                     input logic [7:0] b2);
    mem[a] = b0;
    mem[8'(a + 8'h01)] = b1;
    mem[8'(a + 8'h02)] = b2;
  endtask : put

  // Opcode plus n operand bytes; each byte held until taken
  task automatic run(input logic [15:0] pc, input cod_pkg::cod_kind_t kind, input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge ref_clk);
      fetch_valid = 1'b1;
      fetch_first = (i == 0);
      fetch_byte = mem[8'(pc[7:0] + i)];
      fetch_kind = kind;
      fetch_pc = pc;
      @(posedge ref_clk);
      while (fetch_ready !== 1'b1) @(posedge ref_clk);
    end
    @(negedge ref_clk);
    fetch_valid = 1'b0;
    fetch_first = 1'b0;
    // Released bus shows no stale byte
    fetch_byte = ~fetch_byte;
  endtask : run
endmodule : cod_prog_mem
`default_nettype wire

// >>> testbench/cpu_operand_field_decode_test.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module cpu_operand_field_decode_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic fetch_valid, fetch_ready, fetch_first;
  logic [7:0] fetch_byte;
  cod_pkg::cod_kind_t fetch_kind, dec_kind;
  logic [15:0] fetch_pc, direct_address_operand, eff_addr;
  logic [15:0] index_base = 16'h0000;
  logic [7:0] working_bank_pointer = 8'h5A;
  logic [7:0] literal_byte_operand, vector_addr, wb_data;
  logic [7:0] src_val = 8'h00;
  logic [7:0] dst_val = 8'h00;
  logic [11:0] src_addr, dst_addr, wb_addr;
  logic [2:0] bit_num;
  logic bit_polarity, pair_err, add_req, dec_valid, wb_valid;
  logic val_valid = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  cod_prog_mem mem_u (.ref_clk(ref_clk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_first(fetch_first), .fetch_byte(fetch_byte), .fetch_kind(fetch_kind),
    .fetch_pc(fetch_pc));

  cod_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .fetch_first(fetch_first), .fetch_byte(fetch_byte),
    .fetch_kind(fetch_kind), .fetch_pc(fetch_pc), .working_bank_pointer(working_bank_pointer),
    .index_base(index_base), .dec_valid(dec_valid), .dec_kind(dec_kind), .src_addr(src_addr),
    .dst_addr(dst_addr), .direct_address_operand(direct_address_operand),
    .literal_byte_operand(literal_byte_operand), .bit_num(bit_num),
    .bit_polarity(bit_polarity), .vector_addr(vector_addr), .eff_addr(eff_addr),
    .pair_err(pair_err), .add_req(add_req), .val_valid(val_valid), .src_val(src_val),
    .dst_val(dst_val), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Runs one instruction; the decode pulse must stand in the cycle after the last byte
  task automatic issue(input logic [15:0] pc, input cod_pkg::cod_kind_t k, input int n);
    mem_u.run(pc, k, n);
    `CHK("dec_valid", 1'b1, dec_valid)
    `CHK("dec_kind", k, dec_kind)
  endtask : issue

  // Add with given source and destination values, checks write-back
  task automatic do_add(input logic [7:0] pc, input logic [11:0] es, input logic [11:0] ed,
                        input logic [7:0] a, input logic [7:0] b);
    issue({8'h00, pc}, cod_pkg::K_ADD_RR, 2);
    `CHK("src_addr", es, src_addr)
    `CHK("dst_addr", ed, dst_addr)
    `CHK("add_req", 1'b1, add_req)
    `CHK("fetch_ready", 1'b0, fetch_ready)
    val_valid = 1'b1;
    src_val = a;
    dst_val = b;
    @(negedge ref_clk);
    val_valid = 1'b0;
    src_val = ~a;
    dst_val = ~b;
    `CHK("wb_valid", 1'b1, wb_valid)
    `CHK("wb_addr", ed, wb_addr)
    `CHK("wb_data", 8'(a + b), wb_data)
    `CHK("add_req_off", 1'b0, add_req)
  endtask : do_add

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_add;
    mem_u.put(8'h10, 8'h04, 8'hE8, 8'h43);
    mem_u.put(8'h13, 8'h04, 8'hFF, 8'hE0);
    mem_u.put(8'h16, 8'h04, 8'h08, 8'h43);
    do_add(8'h10, 12'hA58, 12'h043, 8'hF0, 8'h25);
    do_add(8'h13, 12'h0FF, 12'hA50, 8'h80, 8'h80);
    do_add(8'h16, 12'h008, 12'h043, 8'h01, 8'h02);
    // Same format under another opcode decodes but starts no add
    mem_u.put(8'h19, 8'h05, 8'h08, 8'hE2);
    issue(16'h0019, cod_pkg::K_ADD_RR, 2);
    `CHK("other_src", 12'h008, src_addr)
    `CHK("other_dst", 12'hA52, dst_addr)
    `CHK("other_no_add", 1'b0, add_req)
  endtask : t_add

  task automatic t_wide;
    mem_u.put(8'h20, 8'h11, 8'hAF, 8'hFF);
    mem_u.put(8'h23, 8'h22, 8'hFE, 8'h01);
    mem_u.put(8'h26, 8'h33, 8'h12, 8'hFF);
    issue(16'h0020, cod_pkg::K_LONG, 2);
    `CHK("long", 12'hFFF, dst_addr)
    issue(16'h0023, cod_pkg::K_DIRECT, 2);
    `CHK("direct", 16'hFE01, direct_address_operand)
    issue(16'h0026, cod_pkg::K_LITERAL, 2);
    `CHK("literal", 8'hFF, literal_byte_operand)
    `CHK("lit_dst", 12'h012, dst_addr)
  endtask : t_wide

  task automatic t_bit;
    mem_u.put(8'h30, 8'h44, 8'h0F, 8'h30);
    mem_u.put(8'h33, 8'h44, 8'h00, 8'hE1);
    issue(16'h0030, cod_pkg::K_BIT, 2);
    `CHK("bit_num", 3'h7, bit_num)
    `CHK("bit_pol", 1'b1, bit_polarity)
    `CHK("bit_dst", 12'h030, dst_addr)
    // Another bank pointer, taken with the opcode byte
    working_bank_pointer = 8'h3C;
    issue(16'h0033, cod_pkg::K_BIT, 2);
    `CHK("bit_num0", 3'h0, bit_num)
    `CHK("bit_pol0", 1'b0, bit_polarity)
    `CHK("bit_dst_esc", 12'hC31, dst_addr)
    working_bank_pointer = 8'h5A;
  endtask : t_bit

  task automatic t_jump_index;
    mem_u.put(8'h40, 8'h8B, 8'h80, 8'h00);
    mem_u.put(8'h42, 8'h8B, 8'h7F, 8'h00);
    mem_u.put(8'h48, 8'h55, 8'h10, 8'h80);
    issue(16'h0040, cod_pkg::K_JUMP, 1);
    `CHK("jump_neg", 16'hFFC2, eff_addr)
    issue(16'h0042, cod_pkg::K_JUMP, 1);
    `CHK("jump_pos", 16'h00C3, eff_addr)
    index_base = 16'h1000;
    issue(16'h0048, cod_pkg::K_INDEX, 2);
    `CHK("index", 16'h0F80, eff_addr)
    `CHK("index_base_reg", 12'h010, src_addr)
  endtask : t_jump_index

  task automatic t_pairs;
    mem_u.put(8'h50, 8'h66, 8'h21, 8'h00);
    mem_u.put(8'h52, 8'h66, 8'hFE, 8'h00);
    mem_u.put(8'h54, 8'h77, 8'hE3, 8'h00);
    mem_u.put(8'h56, 8'h77, 8'hE4, 8'h00);
    issue(16'h0050, cod_pkg::K_PTR_PAIR, 1);
    `CHK("ppair_odd", 1'b1, pair_err)
    issue(16'h0052, cod_pkg::K_PTR_PAIR, 1);
    `CHK("ppair_even", 1'b0, pair_err)
    issue(16'h0054, cod_pkg::K_WPAIR, 1);
    `CHK("wpair_odd", 1'b1, pair_err)
    issue(16'h0056, cod_pkg::K_WPAIR, 1);
    `CHK("wpair_even", 1'b0, pair_err)
    `CHK("wpair_addr", 12'hA54, src_addr)
  endtask : t_pairs

  task automatic t_vec_ptr;
    mem_u.put(8'h60, 8'h88, 8'hFF, 8'h00);
    mem_u.put(8'h62, 8'h99, 8'hC7, 8'h00);
    issue(16'h0060, cod_pkg::K_VECTOR, 1);
    `CHK("vector", 8'hFF, vector_addr)
    issue(16'h0062, cod_pkg::K_PTR, 1);
    `CHK("ptr", 12'h0C7, src_addr)
  endtask : t_vec_ptr

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge ref_clk);
    `CHK("rst_ready", 1'b1, fetch_ready)
    `CHK("rst_dec", 1'b0, dec_valid)
    resetn = 1'b1;
    t_add();
    t_wide();
    t_bit();
    t_jump_index();
    t_pairs();
    t_vec_ptr();
    tally_and_finish();
  end
endmodule : cpu_operand_field_decode_test
`default_nettype wire
